// File: hco_actuator_model.sv
// behavioural heater and cooler loads that count energised clocks
`timescale 1ns/1ps
`default_nettype none
module hco_actuator_model (
	input  wire logic   clk_i,
	input  wire logic   nrst_i,
	input  wire logic   clr_i,
	input  wire logic   heat_i,
	input  wire logic   cool_i,
	output logic [15:0] heat_cnt_o,
	output logic [15:0] cool_cnt_o
);
	// the load integrates on time, so duty is judged over whole cycles
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			heat_cnt_o <= 16'h0000;
			cool_cnt_o <= 16'h0000;
		end else if (clr_i) begin
			heat_cnt_o <= 16'h0000;
			cool_cnt_o <= 16'h0000;
		end else begin
			heat_cnt_o <= heat_cnt_o + 16'(heat_i);
			cool_cnt_o <= cool_cnt_o + 16'(cool_i);
		end
	end
endmodule : hco_actuator_model
`default_nettype wire

// File: hco_output_ctrl.sv
// heat-cool output control stage with AXI4-Lite register slave
// Contract
// - proportional band zero selects on-off control of output one around setpoint.
// - output-one hysteresis acts and shows only while proportional band is zero.
// - on-off ignores and hides integral, derivative, cycle, offset, cooling band, limit; in PID-PID output two still uses cooling band and its cycle.
// - on-off disables manual mode, auto-tune, self-tune and bumpless transfer.
// - integral zero with nonzero band gives P or PD with manual offset.
// - manual offset is 0 to 100.0 percent, added to proportional output.
// - P or PD control disables auto-tune and self-tune.
// - cycle time applies to relay and SSR types, ignored for linear outputs.
// - direct action gives cooling: output rises as process rises over setpoint.
// - six heat-cool combinations; on-off side driven by matching normal-mode alarm.
// - PID heat with PID cool: output one heats, output two cools.
// - cooling band is 1 to 255 percent of active band.
// - tuning never changes the cooling band.
// - dead band spans minus to plus 36.0 percent of active band.
// - negative dead band gives overlap where both outputs act.
// - positive dead band gives gap where neither output acts.
// - self-tune selector yes enables, none disables self-tuning.
`timescale 1ns/1ps
`default_nettype none
`include "hco_regs.svh"
module hco_output_ctrl #(
	parameter int unsigned TICK_CYCLES = `HCO_TICK_MS * `HCO_CLK_KHZ,
	parameter int unsigned AW          = 8
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic [15:0]   pv_i,
	input  wire logic [AW-1:0] s_axi_awaddr_i,
	input  wire logic          s_axi_awvalid_i,
	output logic               s_axi_awready_o,
	input  wire logic [31:0]   s_axi_wdata_i,
	input  wire logic [3:0]    s_axi_wstrb_i,
	input  wire logic          s_axi_wvalid_i,
	output logic               s_axi_wready_o,
	output logic [1:0]         s_axi_bresp_o,
	output logic               s_axi_bvalid_o,
	input  wire logic          s_axi_bready_i,
	input  wire logic [AW-1:0] s_axi_araddr_i,
	input  wire logic          s_axi_arvalid_i,
	output logic               s_axi_arready_o,
	output logic [31:0]        s_axi_rdata_o,
	output logic [1:0]         s_axi_rresp_o,
	output logic               s_axi_rvalid_o,
	input  wire logic          s_axi_rready_i,
	output logic               out_one_function_o,
	output logic               out_two_function_o,
	output logic               alarm_o,
	output logic [9:0]         out_one_function_pct_o,
	output logic [9:0]         out_two_function_pct_o,
	output hco_pkg::hco_en_s   en_o
);
	import hco_pkg::*;

	if (AW < 7 || TICK_CYCLES < 2) begin : g_chk
		$error("hco_output_ctrl: AW must be 7 or more and TICK_CYCLES 2 or more");
	end

	function automatic logic hit(input logic [AW-1:0] a, input logic wr);
		if (a[AW-1:6] != '0) hit = 1'b0;
		else if (a[5:2] <= `HCO_I_ASP) hit = 1'b1;
		else if (!wr && a[5:2] == `HCO_I_STS) hit = 1'b1;
		else hit = 1'b0;
	endfunction : hit

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		merge = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) merge[b*8 +: 8] = d[b*8 +: 8];
		end
	endfunction : merge

	// out-of-range writes saturate rather than error, so software can never break the law
	function automatic logic [15:0] lim(input logic [3:0] i, input logic [15:0] v);
		lim = v;
		if (i == `HCO_I_CPB) begin
			if (v < `HCO_CPB_MIN) lim = `HCO_CPB_MIN;
			else if (v > `HCO_CPB_MAX) lim = `HCO_CPB_MAX;
		end else if (i == `HCO_I_DB) begin
			if ($signed(v) > $signed(`HCO_DB_LIM)) lim = 16'(`HCO_DB_LIM);
			else if ($signed(v) < -$signed(`HCO_DB_LIM)) lim = 16'(-`HCO_DB_LIM);
		end else if (i == `HCO_I_OFS && v > `HCO_PCT_MAX) begin
			lim = 16'(`HCO_PCT_MAX);
		end
	endfunction : lim

	function automatic logic [15:0] rst_val(input int i);
		case (i)
			`HCO_I_SP:   rst_val = `HCO_RST_SP;
			`HCO_I_PB:   rst_val = `HCO_RST_PB;
			`HCO_I_TI:   rst_val = `HCO_RST_TI;
			`HCO_I_TD:   rst_val = `HCO_RST_TD;
			`HCO_I_HY:   rst_val = `HCO_RST_HY;
			`HCO_I_OFS:  rst_val = `HCO_RST_OFS;
			`HCO_I_CPB:  rst_val = `HCO_RST_CPB;
			`HCO_I_DB:   rst_val = `HCO_RST_DB;
			`HCO_I_AHY:  rst_val = `HCO_RST_AHY;
			`HCO_I_ASP:  rst_val = `HCO_RST_ASP;
			default:     rst_val = `HCO_RST_CYC;
		endcase
	endfunction : rst_val

	function automatic logic [9:0] clampp(input logic signed [31:0] v);
		if (v < 0) clampp = '0;
		else if (v > $signed(`HCO_PCT_MAX)) clampp = 10'(`HCO_PCT_MAX);
		else clampp = v[9:0];
	endfunction : clampp

	// bus slave and register file
	logic        wrdy_ff, nxt_wrdy, rrdy_ff, nxt_rrdy, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata, ctrl_ff, nxt_ctrl;
	logic [15:0] cfg_ff [`HCO_I_SP:`HCO_I_ASP];
	logic [15:0] nxt_cfg [`HCO_I_SP:`HCO_I_ASP];
	hco_sts_s    sts_ff, nxt_sts;

	always_comb begin
		logic [3:0]  wi;
		logic [3:0]  ri;
		logic [31:0] wm;
		wi = s_axi_awaddr_i[5:2];
		ri = s_axi_araddr_i[5:2];
		wm = '0;
		nxt_wrdy = s_axi_awvalid_i && s_axi_wvalid_i && !wrdy_ff && !bvalid_ff;
		nxt_rrdy = s_axi_arvalid_i && !rrdy_ff && !rvalid_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready_i;
		nxt_rvalid = rvalid_ff && !s_axi_rready_i;
		nxt_bresp = bresp_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		nxt_cfg = cfg_ff;
		if (wrdy_ff) begin
			nxt_bvalid = 1'b1;
			nxt_bresp = hit(s_axi_awaddr_i, 1'b1) ? `HCO_OKAY : `HCO_SLVERR;
			if (!hit(s_axi_awaddr_i, 1'b1)) begin
				nxt_bvalid = 1'b1;
			end else if (wi == `HCO_I_CTRL) begin
				nxt_ctrl = merge(ctrl_ff, s_axi_wdata_i, s_axi_wstrb_i);
			end else begin
				wm = merge({16'h0000, cfg_ff[wi]}, s_axi_wdata_i, s_axi_wstrb_i);
				nxt_cfg[wi] = lim(wi, wm[15:0]);
			end
		end
		if (rrdy_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = hit(s_axi_araddr_i, 1'b0) ? `HCO_OKAY : `HCO_SLVERR;
			if (!hit(s_axi_araddr_i, 1'b0)) nxt_rdata = '0;
			else if (ri == `HCO_I_CTRL) nxt_rdata = ctrl_ff;
			else if (ri == `HCO_I_STS) nxt_rdata = sts_ff;
			else nxt_rdata = {16'h0000, cfg_ff[ri]};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wrdy_ff <= 1'b0;
			rrdy_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			bresp_ff <= `HCO_OKAY;
			rresp_ff <= `HCO_OKAY;
			rdata_ff <= '0;
			ctrl_ff <= `HCO_RST_CTRL;
			for (int i = `HCO_I_SP; i <= `HCO_I_ASP; i++) cfg_ff[i] <= rst_val(i);
		end else begin
			wrdy_ff <= nxt_wrdy;
			rrdy_ff <= nxt_rrdy;
			bvalid_ff <= nxt_bvalid;
			rvalid_ff <= nxt_rvalid;
			bresp_ff <= nxt_bresp;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			ctrl_ff <= nxt_ctrl;
			cfg_ff <= nxt_cfg;
		end
	end

	assign s_axi_awready_o = wrdy_ff;
	assign s_axi_wready_o  = wrdy_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = rrdy_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign s_axi_rdata_o   = rdata_ff;

	// control law
	hco_ctrl_s ctl;
	logic                onoff, pmode, pid, hc6, lin1, lin2, cool_alm, heat_alm, alm_ok;
	logic signed [31:0]  pb, ti, pbc, e, half, p1, p2, it, mr, raw1, raw2, lvl, ah, hh;
	logic signed [47:0]  dterm;
	logic signed [31:0]  acc_ff, nxt_acc, eprev_ff, nxt_eprev;
	logic [31:0]         tk_ff, nxt_tk, ph1_ff, nxt_ph1, ph2_ff, nxt_ph2, cy1, cy2;
	logic                hys_ff, nxt_hys, alm_ff, nxt_alm, o1_ff, nxt_o1, o2_ff, nxt_o2, tick;
	logic [9:0]          pct1, pct2, pc1_ff, nxt_pc1, pc2_ff, nxt_pc2;
	hco_en_s             en_ff, nxt_en;

	always_comb begin
		ctl = hco_ctrl_s'(ctrl_ff);
		pb = 32'(cfg_ff[`HCO_I_PB]);
		ti = 32'(cfg_ff[`HCO_I_TI]);
		onoff = (pb == 0);
		pmode = !onoff && ti == 0;
		pid = !onoff && ti != 0;
		hc6 = ctl.combo == HC_PID_PID;
		lin1 = ctl.o1_type >= `HCO_TY_LIN;
		lin2 = ctl.o2_type >= `HCO_TY_LIN;
		e = ctl.direct ? 32'($signed(pv_i)) - 32'($signed(cfg_ff[`HCO_I_SP]))
			: 32'($signed(cfg_ff[`HCO_I_SP])) - 32'($signed(pv_i));
		if (onoff) pb = 32'sd1; // guards the divide; band unused in on-off
		half = hc6 ? ((32'($signed(cfg_ff[`HCO_I_DB])) * pb) / $signed(`HCO_PCT_MAX)) >>> 1
			: 32'sd0;
		pbc = (pb * 32'(cfg_ff[`HCO_I_CPB])) / $signed(`HCO_HUNDRED);
		if (pbc == 0) pbc = 32'sd1;
		// positive dead band shifts both sides apart, negative lets them overlap
		p1 = ((e - half) * $signed(`HCO_PCT_MAX)) / pb;
		p2 = ((-e - half) * $signed(`HCO_PCT_MAX)) / pbc;
		dterm = onoff ? 48'sd0 : (48'(e - eprev_ff) * $signed(48'(cfg_ff[`HCO_I_TD]))
			* $signed(`HCO_D_GAIN)) / 48'(pb);
		it = pid ? acc_ff / $signed(`HCO_HUNDRED) : 32'sd0;
		mr = pmode ? 32'(cfg_ff[`HCO_I_OFS]) : 32'sd0;
		raw1 = p1 + it + mr + dterm[31:0];
		raw2 = p2 - it - dterm[31:0];
		pct1 = onoff ? '0 : clampp(raw1);
		pct2 = hc6 ? clampp(raw2) : '0;
		nxt_acc = acc_ff;
		if (!pid) nxt_acc = '0;
		else if (tick) nxt_acc = acc_ff + (p1 * $signed(`HCO_I_GAIN)) / ti;
		if (nxt_acc > $signed(`HCO_ACC_LIM)) nxt_acc = `HCO_ACC_LIM;
		else if (nxt_acc < -$signed(`HCO_ACC_LIM)) nxt_acc = -`HCO_ACC_LIM;
		nxt_eprev = tick ? e : eprev_ff;
		// signed threshold, else a negative error compares as huge and switches on
		hh = $signed(32'(cfg_ff[`HCO_I_HY] >> 1));
		nxt_hys = 1'b0;
		if (onoff) begin
			if (e > hh) nxt_hys = 1'b1;
			else if (e < -hh) nxt_hys = 1'b0;
			else nxt_hys = hys_ff;
		end
		cool_alm = ctl.combo inside {HC_ONOFF_ONOFF, HC_P_ONOFF, HC_PID_ONOFF};
		heat_alm = ctl.combo inside {HC_ONOFF_P, HC_ONOFF_PID};
		alm_ok = ctl.alm_normal && ((cool_alm && ctl.alm_fn inside {AF_DEV_HI, AF_PROC_HI})
			|| (heat_alm && ctl.alm_fn inside {AF_DEV_LO, AF_PROC_LO}));
		lvl = 32'($signed(cfg_ff[`HCO_I_ASP]));
		if (ctl.alm_fn inside {AF_DEV_HI, AF_DEV_LO}) lvl = lvl + 32'($signed(cfg_ff[`HCO_I_SP]));
		ah = 32'(cfg_ff[`HCO_I_AHY] >> 1);
		nxt_alm = 1'b0;
		if (alm_ok && cool_alm) begin
			if (32'($signed(pv_i)) > lvl + ah) nxt_alm = 1'b1;
			else if (32'($signed(pv_i)) < lvl - ah) nxt_alm = 1'b0;
			else nxt_alm = alm_ff;
		end else if (alm_ok) begin
			if (32'($signed(pv_i)) < lvl - ah) nxt_alm = 1'b1;
			else if (32'($signed(pv_i)) > lvl + ah) nxt_alm = 1'b0;
			else nxt_alm = alm_ff;
		end
		nxt_en.manual = !onoff && ctl.manual;
		nxt_en.bumpless = !onoff && ctl.bumpless;
		nxt_en.autotune = pid && ctl.autotune;
		nxt_en.self_tune = pid && ctl.self_tune;
	end

	// time proportioning on a 100 ms tick; cycle registers hold tenths of a second
	always_comb begin
		tick = tk_ff == TICK_CYCLES - 1;
		nxt_tk = tick ? '0 : tk_ff + 32'd1;
		cy1 = cfg_ff[`HCO_I_OUT_ONE_CYCLE_TIME] == '0 ? 32'd1 : 32'(cfg_ff[`HCO_I_OUT_ONE_CYCLE_TIME]);
		cy2 = cfg_ff[`HCO_I_OUT_TWO_CYCLE_TIME] == '0 ? 32'd1 : 32'(cfg_ff[`HCO_I_OUT_TWO_CYCLE_TIME]);
		nxt_ph1 = ph1_ff;
		nxt_ph2 = ph2_ff;
		if (tick) begin
			nxt_ph1 = ph1_ff + 32'd1 >= cy1 ? '0 : ph1_ff + 32'd1;
			nxt_ph2 = ph2_ff + 32'd1 >= cy2 ? '0 : ph2_ff + 32'd1;
		end
		if (onoff) nxt_o1 = nxt_hys;
		else if (lin1) nxt_o1 = pct1 != '0;
		else nxt_o1 = ph1_ff * `HCO_PCT_MAX < 32'(pct1) * cy1;
		nxt_o2 = hc6 && (lin2 ? pct2 != '0 : ph2_ff * `HCO_PCT_MAX < 32'(pct2) * cy2);
		nxt_pc1 = onoff ? (nxt_hys ? 10'(`HCO_PCT_MAX) : '0) : pct1;
		nxt_pc2 = pct2;
		nxt_sts = '0;
		nxt_sts.pct1 = nxt_pc1;
		nxt_sts.pct2 = nxt_pc2;
		nxt_sts.hy_vis = onoff;
		nxt_sts.tune_vis = !onoff;
		nxt_sts.ofs_vis = pmode;
		nxt_sts.out_one_function = nxt_o1;
		nxt_sts.out_two_function = nxt_o2;
		nxt_sts.alarm = nxt_alm;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_ff <= '0;
			eprev_ff <= '0;
			hys_ff <= 1'b0;
			alm_ff <= 1'b0;
			en_ff <= '0;
			tk_ff <= '0;
			ph1_ff <= '0;
			ph2_ff <= '0;
			o1_ff <= 1'b0;
			o2_ff <= 1'b0;
			pc1_ff <= '0;
			pc2_ff <= '0;
			sts_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
			eprev_ff <= nxt_eprev;
			hys_ff <= nxt_hys;
			alm_ff <= nxt_alm;
			en_ff <= nxt_en;
			tk_ff <= nxt_tk;
			ph1_ff <= nxt_ph1;
			ph2_ff <= nxt_ph2;
			o1_ff <= nxt_o1;
			o2_ff <= nxt_o2;
			pc1_ff <= nxt_pc1;
			pc2_ff <= nxt_pc2;
			sts_ff <= nxt_sts;
		end
	end

	assign out_one_function_o = o1_ff;
	assign out_two_function_o = o2_ff;
	assign alarm_o = alm_ff;
	assign out_one_function_pct_o = pc1_ff;
	assign out_two_function_pct_o = pc2_ff;
	assign en_o = en_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_wr_take;
		s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i;
	endsequence
	property p_onoff_on;
		onoff && e > hh |=> out_one_function_o && out_one_function_pct_o == 10'(`HCO_PCT_MAX);
	endproperty
	a_onoff_on: assert property (p_onoff_on) else $error("on-off output not on");
	property p_hy_vis;
		$past(nrst_i) |-> sts_ff.hy_vis == $past(cfg_ff[`HCO_I_PB] == '0)
			&& sts_ff.tune_vis != sts_ff.hy_vis;
	endproperty
	a_hy_vis: assert property (p_hy_vis) else $error("visibility flags wrong");
	property p_onoff_off;
		onoff |=> en_o == '0 ##0 acc_ff == 0;
	endproperty
	a_onoff_off: assert property (p_onoff_off) else $error("on-off left a feature on");
	property p_pmode_tune;
		pmode |=> !en_o.autotune && !en_o.self_tune;
	endproperty
	a_pmode_tune: assert property (p_pmode_tune) else $error("tuning on in P mode");
	property p_self;
		pid && $stable(ctrl_ff) |=> en_o.self_tune == $past(ctl.self_tune);
	endproperty
	a_self: assert property (p_self) else $error("self-tune selector ignored");
	property p_ofs;
		pmode && !hc6 && e == 0 && dterm == 0 |=> out_one_function_pct_o == $past(cfg_ff[`HCO_I_OFS][9:0]);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset not applied at zero error");
	property p_lin;
		!onoff && lin1 && pct1 != '0 |=> out_one_function_o;
	endproperty
	a_lin: assert property (p_lin) else $error("linear output gated by cycle");
	property p_cpb;
		cfg_ff[`HCO_I_CPB] >= `HCO_CPB_MIN && cfg_ff[`HCO_I_CPB] <= `HCO_CPB_MAX;
	endproperty
	a_cpb: assert property (p_cpb) else $error("cooling band out of range");
	property p_alm;
		$rose(alarm_o) |-> $past(alm_ok);
	endproperty
	a_alm: assert property (p_alm) else $error("alarm side driven without valid setup");
	property p_single2;
		!hc6 |=> !out_two_function_o && out_two_function_pct_o == '0;
	endproperty
	a_single2: assert property (p_single2) else $error("output two active outside PID-PID");
	property p_wr;
		s_wr_take |=> s_axi_bvalid_o;
	endproperty
	a_wr: assert property (p_wr) else $error("write not answered next cycle");
endmodule : hco_output_ctrl
`default_nettype wire

// File: hco_pkg.sv
// types shared by the heat-cool output stage
`default_nettype none
package hco_pkg;
	typedef enum logic [2:0] {HC_SINGLE, HC_ONOFF_ONOFF, HC_ONOFF_P, HC_ONOFF_PID,
		HC_P_ONOFF, HC_PID_ONOFF, HC_PID_PID} hco_mode_e;
	typedef enum logic [2:0] {AF_NONE, AF_DEV_HI, AF_DEV_LO, AF_PROC_HI, AF_PROC_LO} hco_afn_e;
	typedef struct packed {
		logic [11:0] rsvd;
		logic        alm_normal;
		hco_afn_e    alm_fn;
		logic [3:0]  o2_type;
		logic [3:0]  o1_type;
		logic        bumpless;
		logic        manual;
		logic        autotune;
		logic        self_tune;
		hco_mode_e   combo;
		logic        direct;
	} hco_ctrl_s;
	typedef struct packed {
		logic [5:0] rsvd;
		logic       alarm;
		logic       out_two_function;
		logic       out_one_function;
		logic       ofs_vis;
		logic       tune_vis;
		logic       hy_vis;
		logic [9:0] pct2;
		logic [9:0] pct1;
	} hco_sts_s;
	typedef struct packed {
		logic manual;
		logic autotune;
		logic self_tune;
		logic bumpless;
	} hco_en_s;
endpackage : hco_pkg
`default_nettype wire

// File: hco_regs.svh
// register indices, reset values and scaling constants of the heat-cool output stage
`ifndef HCO_REGS_SVH
`define HCO_REGS_SVH
// word index; byte address is index times four
`define HCO_I_CTRL   4'h0
`define HCO_I_SP     4'h1
`define HCO_I_PB     4'h2
`define HCO_I_TI     4'h3
`define HCO_I_TD     4'h4
`define HCO_I_HY     4'h5
`define HCO_I_OFS    4'h6
`define HCO_I_OUT_ONE_CYCLE_TIME   4'h7
`define HCO_I_OUT_TWO_CYCLE_TIME   4'h8
`define HCO_I_CPB    4'h9
`define HCO_I_DB     4'ha
`define HCO_I_AHY    4'hb
`define HCO_I_ASP    4'hc
`define HCO_I_STS    4'hd
`define HCO_RST_CTRL 32'h0000_0000
`define HCO_RST_SP   16'h0064
`define HCO_RST_PB   16'h00c8
`define HCO_RST_TI   16'h0064
`define HCO_RST_TD   16'h0019
`define HCO_RST_HY   16'h0002
`define HCO_RST_OFS  16'h0000
`define HCO_RST_CYC  16'h0014
`define HCO_RST_CPB  16'h0064
`define HCO_RST_DB   16'h0000
`define HCO_RST_AHY  16'h0002
`define HCO_RST_ASP  16'h0000
`define HCO_PCT_MAX  32'h0000_03e8
`define HCO_CPB_MIN  16'h0001
`define HCO_CPB_MAX  16'h00ff
`define HCO_DB_LIM   32'h0000_0168
`define HCO_ACC_LIM  32'h0001_86a0
`define HCO_HUNDRED  32'h0000_0064
`define HCO_I_GAIN   32'h0000_000a
`define HCO_D_GAIN   48'h0000_0000_2710
`define HCO_TY_LIN   4'h3
`define HCO_TICK_MS  32'h0000_0064
`define HCO_CLK_KHZ  32'h0003_0d40
`define HCO_OKAY     2'h0
`define HCO_SLVERR   2'h2
`endif

// File: heat_cool_output_control_tb_top.sv
// register-level testbench of the heat-cool output stage
`timescale 1ns/1ps
`default_nettype none
module heat_cool_output_control_tb_top;
	import hco_pkg::*;
	logic        clk, nrst, clr, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, out_one_function, out_two_function, alarm;
	logic [15:0] pv, hcnt, ccnt;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0]  bresp, rresp;
	logic [9:0]  pct1, pct2;
	hco_en_s     en;
	int          miscompares, cmp_count, cyc;
	logic [31:0] rst_tab [13] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_00c8, 32'h0000_0064,
		32'h0000_0019, 32'h0000_0002, 32'h0000_0000, 32'h0000_0014, 32'h0000_0014,
		32'h0000_0064, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000};
	logic [15:0] oo_pv [4] = '{16'h005a, 16'h0061, 16'h006a, 16'h0061};
	logic        oo_on [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic [15:0] p_pv [3] = '{16'h0032, 16'hfe0c, 16'h00c8};
	logic [31:0] p_pct [3] = '{32'h0000_015e, 32'h0000_03e8, 32'h0000_0000};
	logic [31:0] alm_on [3] = '{32'h0009_000a, 32'h000b_0008, 32'h0009_0002};
	logic [31:0] alm_off [3] = '{32'h0001_0002, 32'h0009_0000, 32'h0009_0004};

	hco_output_ctrl #(.TICK_CYCLES(4), .AW(8)) u_dut (
		.clk_i           (clk),
		.nrst_i          (nrst),
		.pv_i            (pv),
		.s_axi_awaddr_i  (awaddr),
		.s_axi_awvalid_i (awvalid),
		.s_axi_awready_o (awready),
		.s_axi_wdata_i   (wdata),
		.s_axi_wstrb_i   (4'hf),
		.s_axi_wvalid_i  (wvalid),
		.s_axi_wready_o  (wready),
		.s_axi_bresp_o   (bresp),
		.s_axi_bvalid_o  (bvalid),
		.s_axi_bready_i  (bready),
		.s_axi_araddr_i  (araddr),
		.s_axi_arvalid_i (arvalid),
		.s_axi_arready_o (arready),
		.s_axi_rdata_o   (rdata),
		.s_axi_rresp_o   (rresp),
		.s_axi_rvalid_o  (rvalid),
		.s_axi_rready_i  (rready),
		.out_one_function_o          (out_one_function),
		.out_two_function_o          (out_two_function),
		.alarm_o         (alarm),
		.out_one_function_pct_o      (pct1),
		.out_two_function_pct_o      (pct2),
		.en_o            (en)
	);
	hco_actuator_model u_load (
		.clk_i      (clk),
		.nrst_i     (nrst),
		.clr_i      (clr),
		.heat_i     (out_one_function),
		.cool_i     (out_two_function),
		.heat_cnt_o (hcnt),
		.cool_cnt_o (ccnt)
	);

	task automatic test_done();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		while (bvalid !== 1'b1) @(posedge clk);
		check("bresp", 32'(bresp), 32'(er));
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rv = rdata;
		check("rresp", 32'(rresp), 32'(er));
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, 2'h0);
		check("rdata", rv, exp);
	endtask : rdc

	task automatic setpv(input logic [15:0] v);
		@(posedge clk);
		pv <= v;
		repeat (3) @(posedge clk);
	endtask : setpv

	// whole cycles of 40 clocks, so the start phase does not matter
	task automatic duty(input logic [15:0] exp);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (401) @(posedge clk);
		check("heat_on_clocks", 32'(hcnt), 32'(exp));
		check("cool_on_clocks", 32'(ccnt), 32'h0000_0000);
	endtask : duty

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		{nrst, clr, awvalid, wvalid, bready, arvalid, rready} = '0;
		pv = 16'h0000;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 13; i++) rdc(8'(i * 4), rst_tab[i]);
		rd(8'h38, 2'h2);
		check("unmapped", rv, 32'h0000_0000);
		rd(8'h80, 2'h2);
		wr(8'h34, 32'h0000_0000, 2'h2);
		wr(8'h40, 32'h0000_0005, 2'h2);
		rdc(8'h04, 32'h0000_0064);
		wr(8'h24, 32'h0000_0000, 2'h0);
		rdc(8'h24, 32'h0000_0001);
		wr(8'h24, 32'h0000_012c, 2'h0);
		rdc(8'h24, 32'h0000_00ff);
		wr(8'h28, 32'h0000_0190, 2'h0);
		rdc(8'h28, 32'h0000_0168);
		wr(8'h28, 32'h0000_fe70, 2'h0);
		rdc(8'h28, 32'h0000_fe98);
		wr(8'h18, 32'h0000_07d0, 2'h0);
		rdc(8'h18, 32'h0000_03e8);
		// on-off, offset left at full scale to show it is ignored
		wr(8'h14, 32'h0000_000a, 2'h0);
		wr(8'h00, 32'h0000_00f0, 2'h0);
		wr(8'h08, 32'h0000_0000, 2'h0);
		for (int i = 0; i < 4; i++) begin
			setpv(oo_pv[i]);
			check("out_one_function", 32'(out_one_function), 32'(oo_on[i]));
			check("out_one_function_pct", 32'(pct1), oo_on[i] ? 32'h0000_03e8 : 32'h0000_0000);
		end
		check("en", 32'(en), 32'h0000_0000);
		rd(8'h34, 2'h0);
		check("vis", rv & 32'h0070_0000, 32'h0010_0000);
		wr(8'h00, 32'h0000_00f1, 2'h0);
		setpv(16'h006a);
		check("out_one_function", 32'(out_one_function), 32'h0000_0001);
		setpv(16'h005e);
		check("out_one_function", 32'(out_one_function), 32'h0000_0000);
		// proportional only, linear output
		wr(8'h00, 32'h0000_03f0, 2'h0);
		wr(8'h08, 32'h0000_00c8, 2'h0);
		wr(8'h0c, 32'h0000_0000, 2'h0);
		wr(8'h10, 32'h0000_0000, 2'h0);
		wr(8'h18, 32'h0000_0064, 2'h0);
		for (int i = 0; i < 3; i++) begin
			setpv(p_pv[i]);
			check("out_one_function_pct", 32'(pct1), p_pct[i]);
			check("out_one_function", 32'(out_one_function), 32'(p_pct[i] != 32'h0000_0000));
		end
		check("en", 32'(en), 32'h0000_0009);
		rd(8'h34, 2'h0);
		check("vis", rv & 32'h0070_0000, 32'h0060_0000);
		// 1.0 s cycle suits a solid-state relay
		wr(8'h18, 32'h0000_0000, 2'h0);
		wr(8'h1c, 32'h0000_000a, 2'h0);
		wr(8'h00, 32'h0000_02f0, 2'h0);
		setpv(16'h0000);
		duty(16'h00c8);
		wr(8'h00, 32'h0000_03f0, 2'h0);
		duty(16'h0190);
		// alarm as the on-off side
		wr(8'h30, 32'h0000_000a, 2'h0);
		setpv(16'h0078);
		for (int f = 1; f < 5; f++) begin
			wr(8'h00, 32'h0008_0002 | (32'(f) << 16), 2'h0);
			repeat (2) @(posedge clk);
			check("alarm", 32'(alarm), 32'(f % 2));
		end
		// alarm set first, so a wrong setup must actively drop it
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, alm_on[k], 2'h0);
			repeat (2) @(posedge clk);
			check("alarm", 32'(alarm), 32'h0000_0001);
			wr(8'h00, alm_off[k], 2'h0);
			repeat (2) @(posedge clk);
			check("alarm", 32'(alarm), 32'h0000_0000);
		end
		wr(8'h00, 32'h000a_0006, 2'h0);
		setpv(16'h0050);
		check("alarm", 32'(alarm), 32'h0000_0001);
		// PID heat with PID cool, air cooled
		setpv(16'h0064);
		wr(8'h0c, 32'h0000_0064, 2'h0);
		wr(8'h24, 32'h0000_0064, 2'h0);
		wr(8'h28, 32'h0000_fe98, 2'h0);
		wr(8'h00, 32'h0000_301c, 2'h0);
		setpv(16'h0064);
		check("overlap_heat", 32'(pct1 != 10'h000), 32'h0000_0001);
		check("overlap_cool", 32'(pct2 != 10'h000), 32'h0000_0001);
		check("overlap_out_two_function", 32'(out_two_function), 32'h0000_0001);
		check("en", 32'(en), 32'h0000_0002);
		wr(8'h28, 32'h0000_0168, 2'h0);
		setpv(16'h0064);
		check("gap_heat", 32'(pct1), 32'h0000_0000);
		check("gap_cool", 32'(pct2), 32'h0000_0000);
		check("gap_out_two_function", 32'(out_two_function), 32'h0000_0000);
		wr(8'h00, 32'h0000_000c, 2'h0);
		setpv(16'h0064);
		check("en", 32'(en), 32'h0000_0000);
		rdc(8'h24, 32'h0000_0064);
		test_done();
	end
endmodule : heat_cool_output_control_tb_top
`default_nettype wire
